/* dmx_pkg.sv */
// package: encodings, addresses and register map for the data-move executor
package dmx_pkg;
   // apb register byte offsets
   localparam logic [11:0] OFS_INSTR = 12'h000;
   localparam logic [11:0] OFS_CTRL = 12'h004;
   localparam logic [11:0] OFS_WREG = 12'h008;
   localparam logic [11:0] OFS_BANK = 12'h00C;
   localparam logic [11:0] OFS_PTR0 = 12'h010;
   localparam logic [11:0] OFS_PTR1 = 12'h014;
   localparam logic [11:0] OFS_PTR2 = 12'h018;
   localparam logic [11:0] OFS_STAT = 12'h01C;
   localparam logic [11:0] OFS_MEM_ADDR = 12'h020;
   localparam logic [11:0] OFS_MEM_DATA = 12'h024;
   // control / status bit positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ZERO_BIT = 1;
   localparam int STAT_NEG_BIT = 2;
   localparam int STAT_FAULT_BIT = 3;
   // opcode fields
   localparam logic [5:0] OP_IOR = 6'h04;
   localparam logic [5:0] OP_MOVE_FILE = 6'h14;
   localparam logic [7:0] OP_LOAD_PTR = 8'hEE;
   localparam logic [1:0] LOAD_PTR_SUB = 2'h0;
   localparam logic [7:0] OP2_NOP = 8'hF0;
   localparam logic [3:0] OP_FILE_TO_FILE = 4'hC;
   localparam logic [3:0] OP_SECOND = 4'hF;
   // addressing constants
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [11:0] ADDR_WREG = 12'hFE8;
   localparam logic [11:0] ADDR_PC_LOW = 12'hFF9;
   localparam logic [11:0] ADDR_STACK_LOW = 12'hFFD;
   localparam logic [11:0] ADDR_STACK_UP = 12'hFFF;
   localparam int NUM_PTR = 3;
   // core phase machine: four quarter-cycles per instruction cycle
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} dmx_phase_e;
   // execution states
   typedef enum logic [1:0] {EX_IDLE, EX_FIRST, EX_SECOND} dmx_exec_e;
   // one decoded instruction
   typedef struct packed {
      logic ior;
      logic move_f;
      logic load_ptr;
      logic file_to_file;
   } dmx_kind_s;
   // apb request bundle
   typedef struct packed {
      logic sel;
      logic en;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } dmx_apb_s;
endpackage

/* dmx_exec.sv */
// data-move instruction executor with register file, reached over apb
`timescale 1ns/1ps
// Behaviour
// - a=0 access bank, a=1 bank register
// - extended set, a=0, f<=95: indexed offset
// - pointer literal goes to selected pointer
// - selector names one of three pointers, literal 12 bits
// - literal high nibble to bits 11:8, low byte to bits 7:0
// - move-file destination bit picks W or file
// - 8-bit address reaches whole 256-byte bank
// - file-to-file: 1100 source, 1111 destination words
// - file-to-file spans full 4096-byte space
// - working register usable as ordinary location
module dmx_exec
   import dmx_pkg::*;
#(
   parameter int DATA_DEPTH = 4096
)
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);
   // the data space width is fixed by 12-bit addresses
   if (DATA_DEPTH != 4096) begin : g_chk
      $error("dmx_exec: DATA_DEPTH must be 4096");
   end

   dmx_apb_s req; // bundled bus request
   assign req = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};

   // architectural state
   logic [7:0] mem [DATA_DEPTH]; // whole data space, W lives inside it
   logic [7:0] bank; // bank select register, low nibble used
   logic [11:0] ptr [NUM_PTR]; // indirect pointer registers
   logic ext_en; // extended instruction set enable
   logic flag_z; // zero flag
   logic flag_n; // negative flag
   logic fault; // rejected instruction word or protected move target seen
   logic [15:0] word1; // first instruction word held
   logic [7:0] src_val; // file-to-file source data latched in Q2
   logic [11:0] mem_ptr; // software window into data space
   dmx_phase_e phase;
   dmx_exec_e state;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;

   // full-address decode of an 8-bit file operand
   function automatic logic [11:0] eff_addr(input logic [15:0] w,
      input logic [3:0] bank_sel, input logic ext,
      input logic [11:0] base_ptr);
      logic [7:0] f;
      f = w[7:0];
      if (w[8])
         eff_addr = {bank_sel, f};
      else if (ext && f <= INDEX_LIMIT)
         eff_addr = base_ptr + {4'h0, f};
      else if (f < ACCESS_SPLIT)
         eff_addr = {4'h0, f};
      else
         eff_addr = {ACCESS_HI_BANK, f};
   endfunction

   // classify a first instruction word
   function automatic dmx_kind_s decode(input logic [15:0] w);
      decode.ior = (w[15:10] == OP_IOR);
      decode.move_f = (w[15:10] == OP_MOVE_FILE);
      decode.load_ptr = (w[15:8] == OP_LOAD_PTR)
         && (w[7:6] == LOAD_PTR_SUB)
         && (w[5:4] < 2'(NUM_PTR));
      decode.file_to_file = (w[15:12] == OP_FILE_TO_FILE);
   endfunction

   // apb decode wires
   wire access_ph = req.sel && req.en;
   wire wr_cyc = access_ph && req.wr && pready;
   wire [11:0] reg_ofs = {req.addr[11:2], 2'b00};
   wire hit_instr = (reg_ofs == OFS_INSTR);
   wire hit_ctrl = (reg_ofs == OFS_CTRL);
   wire hit_wreg = (reg_ofs == OFS_WREG);
   wire hit_bank = (reg_ofs == OFS_BANK);
   wire hit_ptr0 = (reg_ofs == OFS_PTR0);
   wire hit_ptr1 = (reg_ofs == OFS_PTR1);
   wire hit_ptr2 = (reg_ofs == OFS_PTR2);
   wire hit_stat = (reg_ofs == OFS_STAT);
   wire hit_maddr = (reg_ofs == OFS_MEM_ADDR);
   wire hit_mdata = (reg_ofs == OFS_MEM_DATA);
   wire mapped = hit_instr | hit_ctrl | hit_wreg | hit_bank | hit_ptr0
      | hit_ptr1 | hit_ptr2 | hit_stat | hit_maddr | hit_mdata;
   wire busy = (state != EX_IDLE);
   // writes to instr (except a second word), W, bank, pointers and data window are refused while an instruction runs
   wire blocked = busy && (hit_instr | hit_wreg | hit_bank | hit_mdata
      | hit_ptr0 | hit_ptr1 | hit_ptr2) && req.wr;
   wire instr_wr = wr_cyc && hit_instr && !busy;

   // execution decode wires
   dmx_kind_s kind;
   assign kind = decode(word1);
   wire [1:0] psel_idx = word1[5:4];
   wire [11:0] f_addr = eff_addr(word1, bank[3:0], ext_en, ptr[2]);
   wire [7:0] f_val = mem[f_addr];
   wire [7:0] w_val = mem[ADDR_WREG];
   wire [7:0] ior_val = w_val | f_val;
   wire [7:0] res = kind.ior ? ior_val : f_val;
   wire [11:0] res_dst = word1[9] ? f_addr : ADDR_WREG;
   wire [15:0] word2 = req.wdata[15:0];
   wire second_ok = (word2[15:12] == OP_SECOND);
   wire [11:0] f2f_dst = word2[11:0];
   // protected destinations are still written; the program must avoid them
   wire f2f_bad = (f2f_dst == ADDR_PC_LOW) ||
      (f2f_dst >= ADDR_STACK_LOW && f2f_dst <= ADDR_STACK_UP);
   wire q4 = (phase == PH_Q4);
   wire single_done = busy && (state == EX_FIRST) && q4
      && (kind.ior || kind.move_f);
   wire need_word2 = kind.load_ptr || kind.file_to_file;
   wire second_wr = wr_cyc && hit_instr && (state == EX_SECOND);

   // quarter-cycle phase counter, runs only while executing
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
         phase <= PH_Q1;
      else if (!busy)
         phase <= PH_Q1;
      else if (state == EX_SECOND && q4 && !second_wr)
         phase <= PH_Q4; // hold Q4 until the second word arrives
      else
         phase <= dmx_phase_e'(phase + 2'd1);
   end

   // instruction sequencer
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state <= EX_IDLE;
         word1 <= 16'h0000;
      end
      else
      begin
         case (state)
            EX_IDLE:
               if (instr_wr)
               begin
                  word1 <= req.wdata[15:0];
                  state <= EX_FIRST;
               end
            EX_FIRST:
               if (q4)
                  state <= need_word2 ? EX_SECOND : EX_IDLE;
            EX_SECOND:
               if (q4 && second_wr)
                  state <= EX_IDLE;
            default:
               state <= EX_IDLE;
         endcase
      end
   end

   // data space: instruction results and software window
   always_ff @(posedge CLOCK)
   begin
      if (single_done && !(kind.move_f && word1[9]))
         mem[res_dst] <= res;
      else if (state == EX_SECOND && q4 && second_wr && kind.file_to_file
         && second_ok)
         mem[f2f_dst] <= src_val;
      else if (wr_cyc && hit_wreg && !busy)
         mem[ADDR_WREG] <= req.wdata[7:0];
      else if (wr_cyc && hit_mdata && !busy)
         mem[mem_ptr] <= req.wdata[7:0];
   end

   // source latch in Q2 of the first cycle
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
         src_val <= 8'h00;
      else if (state == EX_FIRST && phase == PH_Q2 && kind.file_to_file)
         src_val <= mem[word1[11:0]];
   end

   // pointers: high nibble (bits 11:8) in first Q4, low byte in second Q4
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         for (int i = 0; i < NUM_PTR; i++)
            ptr[i] <= 12'h000;
      end
      else if (state == EX_FIRST && q4 && kind.load_ptr)
         ptr[psel_idx][11:8] <= word1[3:0];
      else if (state == EX_SECOND && q4 && second_wr && kind.load_ptr
         && second_ok)
         ptr[psel_idx][7:0] <= word2[7:0];
      else if (wr_cyc && !busy && hit_ptr0)
         ptr[0] <= req.wdata[11:0];
      else if (wr_cyc && !busy && hit_ptr1)
         ptr[1] <= req.wdata[11:0];
      else if (wr_cyc && !busy && hit_ptr2)
         ptr[2] <= req.wdata[11:0];
   end

   // flags and control
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         flag_z <= 1'b0;
         flag_n <= 1'b0;
         fault <= 1'b0;
         ext_en <= 1'b0;
         bank <= 8'h00;
         mem_ptr <= 12'h000;
      end
      else
      begin
         if (single_done)
         begin
            flag_z <= (res == 8'h00);
            flag_n <= res[7];
         end
         // fault is sticky; a new bad word outranks the clearing write
         if (instr_wr && !(|decode(req.wdata[15:0])))
            fault <= 1'b1;
         else if (second_wr && q4 && (!second_ok || f2f_bad))
            fault <= 1'b1;
         else if (wr_cyc && hit_stat && req.wdata[STAT_FAULT_BIT])
            fault <= 1'b0;
         if (wr_cyc && hit_ctrl)
            ext_en <= req.wdata[CTRL_EXT_BIT];
         if (wr_cyc && hit_bank && !busy)
            bank <= {4'h0, req.wdata[3:0]};
         if (wr_cyc && hit_maddr)
            mem_ptr <= req.wdata[11:0];
      end
   end

   // read mux
   wire [31:0] stat_word = {28'h0, fault, flag_n, flag_z, busy};
   wire [31:0] rd_mux =
      hit_ctrl ? {31'h0, ext_en} :
      hit_instr ? {16'h0, word1} :
      hit_wreg ? {24'h0, w_val} :
      hit_bank ? {24'h0, bank} :
      hit_ptr0 ? {20'h0, ptr[0]} :
      hit_ptr1 ? {20'h0, ptr[1]} :
      hit_ptr2 ? {20'h0, ptr[2]} :
      hit_stat ? stat_word :
      hit_maddr ? {20'h0, mem_ptr} :
      hit_mdata ? {24'h0, mem[mem_ptr]} : 32'h0;

   // apb answer: one wait state, second word waits for Q4
   // an early second word is parked until the second cycle reaches Q4
   wire hold_second = hit_instr && req.wr
      && ((state == EX_FIRST && need_word2)
      || (state == EX_SECOND && !q4));
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else if (access_ph && !pready && !hold_second)
      begin
         pready <= 1'b1;
         prdata <= req.wr ? 32'h0 : rd_mux;
         pslverr <= !mapped || (blocked && !(hit_instr
            && state == EX_SECOND));
      end
      else
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
   end

   assign PREADY = pready;
   assign PRDATA = prdata;
   assign PSLVERR = pslverr;
endmodule // dmx_exec

/* dmx_exec_props.sv */
// checker: apb answer timing of the data-move executor
`timescale 1ns/1ps
module dmx_exec_chk
   import dmx_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   // access phase not yet answered
   wire acc = PSEL && PENABLE && !PREADY;
   // no register at 0x040 and above, past the data window
   wire unmap = PADDR[11:6] != 6'h00;
   AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL && PENABLE))
      else $error("ready without access");
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error outside answer");
   AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside answer");
   AST_READ_ONE_WAIT: assert property (acc && !PWRITE |=> PREADY)
      else $error("read not answered after one wait");
   AST_UNMAPPED: assert property (acc && unmap |=> PSLVERR && PRDATA == 0)
      else $error("unmapped access not refused");
   AST_READ_OK: assert property (acc && !PWRITE && !unmap |=> !PSLVERR)
      else $error("mapped read refused");
   AST_WRITE_WAIT: assert property (acc && PWRITE && PADDR != OFS_INSTR
      |=> PREADY) else $error("write not answered after one wait");
   AST_INSTR_BOUND: assert property (
      acc && PWRITE && PADDR == OFS_INSTR |-> ##[1:8] PREADY)
      else $error("instruction write hangs");
endmodule // dmx_exec_chk
bind dmx_exec dmx_exec_chk u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

/* tb.sv */
// testbench: instructions issued over apb against a bench model
`timescale 1ns/1ps
module tb;
   import dmx_pkg::*;
   logic CLOCK;
   logic RESETN;
   dmx_apb_s req; // request bundle
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic [31:0] rd; // last read data
   logic [31:0] rn; // random fields
   logic [1:0] zn; // model n and z flags
   int n_mismatch;
   int checked;
   int mem [4096]; // model data space, w at fe8
   int e, r, s, d;
   dmx_exec u_dut (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(req.sel),
      .PENABLE(req.en), .PWRITE(req.wr), .PADDR(req.addr),
      .PWDATA(req.wdata), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR));
   // 100 mhz clock
   initial
   begin
      CLOCK = 0;
      forever #5 CLOCK = ~CLOCK;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] x);
      checked++;
      if (seen !== x)
      begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", nm, x, seen);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one apb transfer, held until pready; bounded so a hang shows up
   task automatic xf(logic w, logic [11:0] a, logic [31:0] wd, logic er);
      int n;
      req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge CLOCK);
      req.en <= 1'b1;
      n = 0;
      @(posedge CLOCK);
      while (PREADY !== 1'b1 && n < 20)
      begin
         @(posedge CLOCK);
         n++;
      end
      rd = PRDATA;
      chk("resp", {PREADY, PSLVERR}, {1'b1, er});
      req <= '0;
      @(posedge CLOCK);
   endtask
   task automatic rc(logic [11:0] a, logic [31:0] x, string nm);
      xf(1'b0, a, 0, 1'b0);
      chk(nm, rd, x);
   endtask
   // data-space byte write, model follows
   task automatic poke(int a, int x);
      xf(1'b1, OFS_MEM_ADDR, a, 1'b0);
      xf(1'b1, OFS_MEM_DATA, x, 1'b0);
      mem[a] = x;
   endtask
   task automatic peek(int a);
      xf(1'b1, OFS_MEM_ADDR, a, 1'b0);
      rc(OFS_MEM_DATA, mem[a], "mem");
   endtask
   // poll busy with a bound
   task automatic idle;
      int n;
      n = 0;
      rd = 1;
      while (rd[0] !== 1'b0 && n < 30)
      begin
         xf(1'b0, OFS_STAT, 0, 1'b0);
         n++;
      end
   endtask
   // model address of a byte-oriented operand
   function automatic int ea(int fa, int ac, int x, int bk, int p2);
      if (ac)
         return bk * 256 + fa;
      if (x && fa <= 95)
         return (p2 + fa) % 4096;
      return fa < 96 ? fa : 3840 + fa;
   endfunction
   initial
   begin
      #500000;
      n_mismatch++;
      end_sim();
   end
   initial
   begin
      req = '0;
      RESETN = 0;
      r = $urandom(32'hCA66);
      repeat (5) @(posedge CLOCK);
      RESETN <= 1;
      // data memory (and so w) is not reset: skip that offset
      for (int i = 0; i < 9; i++)
         if (i != 2)
            rc(12'(i * 4), 0, "reset");
      xf(1'b0, 12'h040, 0, 1'b1);
      // byte-oriented ops, first four on the index boundary
      for (int i = 0; i < 24; i++)
      begin
         rn = $urandom;
         if (i < 4)
            rn[15:12] = {1'b1, rn[14:13], 1'b0};
         if (i < 4)
            rn[7:0] = i[0] ? 8'h5F : 8'h60;
         xf(1'b1, OFS_CTRL, rn[15], 1'b0);
         xf(1'b1, OFS_BANK, rn[11:8], 1'b0);
         xf(1'b1, OFS_PTR2, rn[27:16], 1'b0);
         e = ea(rn[7:0], rn[12], rn[15], rn[11:8], rn[27:16]);
         poke(e, $urandom % 256);
         r = $urandom % 256;
         xf(1'b1, OFS_WREG, r, 1'b0);
         mem['hFE8] = r;
         r = rn[14] ? mem[e] : mem[e] | mem['hFE8];
         xf(1'b1, OFS_INSTR, {rn[14] ? OP_MOVE_FILE : OP_IOR, rn[13:12],
            rn[7:0]}, 1'b0);
         idle();
         if (rn[13])
            mem[e] = r;
         else
            mem['hFE8] = r;
         zn = {r[7], r == 0};
         rc(OFS_WREG, mem['hFE8], "wreg");
         peek(e);
         rc(OFS_STAT, {zn, 1'b0}, "flags");
      end
      // pointer loads, busy write refused in between
      for (int i = 0; i < 3; i++)
      begin
         rn = $urandom;
         if (i == 0)
            rn[11:0] = 12'hFFF;
         xf(1'b1, OFS_INSTR, {OP_LOAD_PTR, LOAD_PTR_SUB, 2'(i), rn[11:8]},
            1'b0);
         xf(1'b1, OFS_WREG, 8'h55, 1'b1);
         xf(1'b1, OFS_INSTR, {OP2_NOP, rn[7:0]}, 1'b0);
         idle();
         rc(12'(OFS_PTR0 + 4 * i), rn[11:0], "ptr");
      end
      rc(OFS_WREG, mem['hFE8], "wreg");
      // file-to-file moves: w ends, far ends, forbidden target, bad pair
      for (int i = 0; i < 6; i++)
      begin
         s = i == 1 ? 'hFE8 : i == 4 ? 'hFFF : $urandom % 3936;
         d = i == 2 ? 'hFE8 : i == 3 ? 'hFF9 : i == 4 ? 0 : $urandom % 3936;
         if (d == s)
            d = s ^ 1;
         poke(s, $urandom % 256);
         poke(d, mem[s] ^ 255);
         xf(1'b1, OFS_INSTR, {OP_FILE_TO_FILE, 12'(s)}, 1'b0);
         xf(1'b1, OFS_INSTR, {i == 5 ? 4'hE : OP_SECOND, 12'(d)}, 1'b0);
         idle();
         if (i != 5)
            mem[d] = mem[s];
         peek(d);
         rc(OFS_STAT, {i == 3 || i == 5, zn, 1'b0}, "stat");
         xf(1'b1, OFS_STAT, 32'h8, 1'b0);
      end
      end_sim();
   end
endmodule // tb
